// ==== logic/chan_alarm_consts.svh ====
`ifndef CHAN_ALARM_CONSTS_SVH
`define CHAN_ALARM_CONSTS_SVH

// Word indices; byte address is four times the index
`define CAB_IDX_ALARM_CH0   6'h03
`define CAB_IDX_ALARM_CH1   6'h0B
`define CAB_IDX_ALARM_CH2   6'h13
// Distance from a channel's alarm word back to its other words
`define CAB_BACK_CTRL       6'h03
`define CAB_BACK_MASK       6'h02
`define CAB_BACK_INT        6'h01

// Alarm state field positions
`define CAB_BIT_DRIVE       0
`define CAB_BIT_ABSENT      1
`define CAB_BIT_CLKUNL      2
`define CAB_BIT_FIFO        3
`define CAB_BIT_ANALOG      4
`define CAB_BIT_DIGITAL     5
`define CAB_BIT_PRBS        6
`define CAB_BIT_UNUSED      7

// Change-flag and control field positions
`define CAB_INT_DRIVE       0
`define CAB_INT_ABSENT      1
`define CAB_CTRL_PRBS_EN    0

// Reset values
`define CAB_ALARM_RESET     8'h00
`define CAB_INT_RESET       2'h0
`define CAB_MASK_RESET      2'h0
`define CAB_CTRL_RESET      1'h0

// Pattern lock judging: window of received bits and error limits
`define CAB_PRBS_WIN_LAST   10'h3FF
`define CAB_PRBS_LOSS_TH    10'h0C8
`define CAB_PRBS_CLEAR_TH   10'h004

`endif

// ==== logic/chan_alarm_pkg.sv ====
package chan_alarm_pkg;

  // Pattern lock judge states, one-hot
  typedef enum logic [1:0] {
    PATTERN_LOCKED   = 2'b01,
    PATTERN_UNLOCKED = 2'b10
  } prbs_lock_type;

  // Read-back word of the bus
  typedef logic [31:0] bus_word_type;

endpackage

// ==== logic/prbs_lock_monitor.sv ====
`timescale 1ns/10ps
`include "chan_alarm_consts.svh"

module prbs_lock_monitor (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Checker control and bit stream result
  input  wire logic enable,
  input  wire logic bitValid,
  input  wire logic bitError,
  // Judgement
  output logic      lossOfLock
);

  chan_alarm_pkg::prbs_lock_type stateReg;
  chan_alarm_pkg::prbs_lock_type stateNext;
  logic [9:0] winCntReg;
  logic [9:0] winCntNext;
  logic [9:0] errCntReg;
  logic [9:0] errCntNext;
  logic [9:0] errTotal;
  logic       winEnd;

  // Error tally of the window including the current bit
  assign errTotal   = 10'(errCntReg + {9'h000, bitError});
  assign winEnd     = bitValid && (winCntReg == `CAB_PRBS_WIN_LAST);
  assign winCntNext = !enable ? 10'h000 :
                      !bitValid ? winCntReg :
                      winEnd ? 10'h000 : 10'(winCntReg + 10'h001);
  assign errCntNext = !enable ? 10'h000 :
                      !bitValid ? errCntReg :
                      winEnd ? 10'h000 : errTotal;
  assign lossOfLock = (stateReg == chan_alarm_pkg::PATTERN_UNLOCKED);

  // Judge once per window; hysteresis keeps the flag from chattering
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      chan_alarm_pkg::PATTERN_LOCKED: begin
        if (enable && winEnd && errTotal >= `CAB_PRBS_LOSS_TH)
          stateNext = chan_alarm_pkg::PATTERN_UNLOCKED;
      end
      chan_alarm_pkg::PATTERN_UNLOCKED: begin
        if (!enable)
          stateNext = chan_alarm_pkg::PATTERN_LOCKED;
        else if (winEnd && errTotal <= `CAB_PRBS_CLEAR_TH)
          stateNext = chan_alarm_pkg::PATTERN_LOCKED;
      end
      default: stateNext = chan_alarm_pkg::PATTERN_LOCKED;
    endcase
  end

  // State and counters
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stateReg  <= chan_alarm_pkg::PATTERN_LOCKED;
      winCntReg <= 10'h000;
      errCntReg <= 10'h000;
    end else begin
      stateReg  <= stateNext;
      winCntReg <= winCntNext;
      errCntReg <= errCntNext;
    end
  end

endmodule

// ==== logic/channel_alarm_status_bank.sv ====
`timescale 1ns/10ps
`include "chan_alarm_consts.svh"

// Overview of operation
// - Signal-loss change sets change flag bit 1 until read clears it.
// - Drive-monitor change sets change flag bit 0 until read clears it.
// - Read-only alarm word at 0x03, 0x0B, 0x13; resets to zero.
// - Alarm bit 1 shows live signal-loss state, apart from change flag.
// - Alarm bit 0 shows live drive-monitor state, apart from change flag.
// - Pattern checker declares lock loss after very many bit errors.
// - Pattern checker clears lock loss when pattern seen with few errors.
// - Alarm bit 6 is 0 while locked, 1 while lock lost.
// - Signal-loss state is OR of analog and digital detectors.
module channel_alarm_status_bank (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Detector levels, one bit per channel
  input  wire logic [2:0]  analogLoss,
  input  wire logic [2:0]  digitalLoss,
  input  wire logic [2:0]  fifoLimitAlarm,
  input  wire logic [2:0]  clockUnlocked,
  input  wire logic [2:0]  driveMonitorFlag,
  // Pattern checker bit results, one bit per channel
  input  wire logic [2:0]  prbsBitValid,
  input  wire logic [2:0]  prbsBitError,
  // Controls and interrupt
  output logic      [2:0]  prbsEnable,
  output logic             alarmIrq
);

  localparam int NCH = 3;

  // Word map of one channel, counted back from its alarm word:
  //   alarm word   read-only live levels
  //   alarm - 1    change flags, cleared by the read that returns them
  //   alarm - 2    interrupt mask for the change flags
  //   alarm - 3    control, bit 0 enables the pattern checker
  // Offsets that are not multiples of four are word indices, so the
  // byte address is four times the index and every word is aligned.

  // Word index of a channel's alarm word
  // Channels sit eight words apart; the table keeps them explicit
  function automatic logic [5:0] alarmIdx(input int ch);
    case (ch)
      0:       alarmIdx = `CAB_IDX_ALARM_CH0;
      1:       alarmIdx = `CAB_IDX_ALARM_CH1;
      default: alarmIdx = `CAB_IDX_ALARM_CH2;
    endcase
  endfunction

  // Gate a byte by a select
  // Unselected words add zero to the ORed read-back
  function automatic logic [7:0] pick(input logic sel,
                                      input logic [7:0] val);
    pick = sel ? val : 8'h00;
  endfunction

  // Registers
  // All state resets to zero; software must unmask flags and enable checkers
  logic [NCH-1:0][7:0] alarmReg;
  logic [NCH-1:0][7:0] alarmNext;
  logic [NCH-1:0][1:0] intReg;
  logic [NCH-1:0][1:0] intNext;
  logic [NCH-1:0][1:0] maskReg;
  logic [NCH-1:0][1:0] maskNext;
  logic [NCH-1:0]      ctrlReg;
  logic [NCH-1:0]      ctrlNext;
  logic [NCH-1:0]      intSelReg;
  logic [NCH-1:0]      intSelNext;
  logic [31:0]         prdataReg;
  logic [31:0]         prdataNext;
  logic                preadyReg;
  logic                preadyNext;
  logic                pslverrReg;
  logic                pslverrNext;
  logic                irqReg;
  logic                irqNext;

  // Bus decode
  logic [5:0]          wordIdx;
  logic                aligned;
  logic                setupPhase;
  logic                accessDone;
  logic                writeDone;
  logic                readDone;
  logic [NCH-1:0]      hitCtrl;
  logic [NCH-1:0]      hitMask;
  logic [NCH-1:0]      hitInt;
  logic [NCH-1:0]      hitAlarm;
  logic                mapped;
  logic                writable;
  logic [NCH-1:0][7:0] chanRead;
  logic [7:0]          readByte;

  // Per-channel live state and events
  logic [NCH-1:0]      signalAbsent;
  logic [NCH-1:0]      lockLost;
  logic [NCH-1:0]      evtAbsent;
  logic [NCH-1:0]      evtDrive;
  logic [NCH-1:0]      pending;

  // Phase decode; the slave answers in the first access cycle
  // Reads are decoded in setup; writes decode paddr again in the access
  // phase, so paddr must not change inside a transfer
  assign wordIdx    = paddr[7:2];
  assign aligned    = (paddr[1:0] == 2'h0);
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && preadyReg;
  assign writeDone  = accessDone && pwrite && !pslverrReg;
  assign readDone   = accessDone && !pwrite;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_chan
      // Address hits of this channel's four words
      assign hitAlarm[ch] = aligned && (wordIdx == alarmIdx(ch));
      assign hitInt[ch]   = aligned &&
             (wordIdx == 6'(alarmIdx(ch) - `CAB_BACK_INT));
      assign hitMask[ch]  = aligned &&
             (wordIdx == 6'(alarmIdx(ch) - `CAB_BACK_MASK));
      assign hitCtrl[ch]  = aligned &&
             (wordIdx == 6'(alarmIdx(ch) - `CAB_BACK_CTRL));

      // Pattern lock judge, steered by the software enable
      prbs_lock_monitor u_lock (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .enable     (ctrlReg[ch]),
        .bitValid   (prbsBitValid[ch]),
        .bitError   (prbsBitError[ch]),
        .lossOfLock (lockLost[ch])
      );

      // Either detector declaring loss means the signal is absent
      assign signalAbsent[ch] = analogLoss[ch] | digitalLoss[ch];

      // Live alarm word; bit 7 never set
      assign alarmNext[ch][`CAB_BIT_UNUSED]  = 1'b0;
      assign alarmNext[ch][`CAB_BIT_PRBS]    = lockLost[ch];
      assign alarmNext[ch][`CAB_BIT_DIGITAL] = digitalLoss[ch];
      assign alarmNext[ch][`CAB_BIT_ANALOG]  = analogLoss[ch];
      assign alarmNext[ch][`CAB_BIT_FIFO]    = fifoLimitAlarm[ch];
      assign alarmNext[ch][`CAB_BIT_CLKUNL]  = clockUnlocked[ch];
      assign alarmNext[ch][`CAB_BIT_ABSENT]  = signalAbsent[ch];
      assign alarmNext[ch][`CAB_BIT_DRIVE]   = driveMonitorFlag[ch];

      // A change of the signal-loss or drive state against the stored state is an event
      // Flag and stored state move on the same edge; a pulse shorter
      // than one clock is missed, so detectors must hold their levels
      assign evtAbsent[ch] = signalAbsent[ch] ^
                             alarmReg[ch][`CAB_BIT_ABSENT];
      assign evtDrive[ch]  = driveMonitorFlag[ch] ^
                             alarmReg[ch][`CAB_BIT_DRIVE];

      // Clear only bits the reader saw, so a fresh event is never lost
      assign intNext[ch] = (intReg[ch] &
             ~((readDone && intSelReg[ch]) ? prdataReg[1:0] : 2'h0)) |
             {evtAbsent[ch], evtDrive[ch]};

      // Software-written mask and control
      assign maskNext[ch] = (writeDone && hitMask[ch]) ? pwdata[1:0] :
                            maskReg[ch];
      assign ctrlNext[ch] = (writeDone && hitCtrl[ch]) ?
                            pwdata[`CAB_CTRL_PRBS_EN] : ctrlReg[ch];

      // Remember which read takes a change-flag word
      assign intSelNext[ch] = setupPhase ? hitInt[ch] :
                              (accessDone ? 1'b0 : intSelReg[ch]);

      // Read-back contribution of this channel
      assign chanRead[ch] =
             pick(hitAlarm[ch], alarmReg[ch]) |
             pick(hitInt[ch], {6'h00, intReg[ch]}) |
             pick(hitMask[ch], {6'h00, maskReg[ch]}) |
             pick(hitCtrl[ch], {7'h00, ctrlReg[ch]});

      // Unmasked flags of this channel drive the interrupt
      assign pending[ch] = |(intReg[ch] & maskReg[ch]);
    end
  endgenerate

  // Whole-bank decode and bus answer
  // Writes land only on mask and control words
  assign mapped   = |{hitCtrl, hitMask, hitInt, hitAlarm};
  assign writable = |{hitCtrl, hitMask};
  assign readByte = chanRead[0] | chanRead[1] | chanRead[2];

  // Read data is captured in setup; it is the snapshot a read clears
  assign prdataNext  = setupPhase ? {24'h000000, readByte} : prdataReg;
  assign preadyNext  = setupPhase;
  assign pslverrNext = setupPhase ? (!mapped || (pwrite && !writable)) :
                       (accessDone ? 1'b0 : pslverrReg);
  assign irqNext     = |pending;

  // Live alarm words; the stored copy is also the reference
  // against which the change events are judged
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      alarmReg <= {NCH{`CAB_ALARM_RESET}};
    end else begin
      alarmReg <= alarmNext;
    end
  end

  // Change flags; a set in the cycle of the clearing read wins
  // because the event term is ORed in after the clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      intReg <= {NCH{`CAB_INT_RESET}};
    end else begin
      intReg <= intNext;
    end
  end

  // Interrupt masks, written by software only
  // Reset leaves every change flag masked
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      maskReg <= {NCH{`CAB_MASK_RESET}};
    end else begin
      maskReg <= maskNext;
    end
  end

  // Pattern checker enables
  // Clearing one also forces its checker back to locked
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlReg <= {NCH{`CAB_CTRL_RESET}};
    end else begin
      ctrlReg <= ctrlNext;
    end
  end

  // Read data; captured in setup, so the access cycle sees a
  // word that no later event can alter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdataReg <= 32'h00000000;
    end else begin
      prdataReg <= prdataNext;
    end
  end

  // Ready for exactly one cycle after every setup
  // No wait states: every word is answered from flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      preadyReg <= 1'b0;
    end else begin
      preadyReg <= preadyNext;
    end
  end

  // Error answer, raised with ready and dropped after the access
  // Unmapped, misaligned and read-only writes all take it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pslverrReg <= 1'b0;
    end else begin
      pslverrReg <= pslverrNext;
    end
  end

  // Which channel's change-flag word the current read returns
  // Kept to the end of the access so the clear hits one word only
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      intSelReg <= 3'h0;
    end else begin
      intSelReg <= intSelNext;
    end
  end

  // Interrupt level, one edge behind the flags
  // Registered so the pin never glitches on decode
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irqReg <= 1'b0;
    end else begin
      irqReg <= irqNext;
    end
  end

  // Outputs straight from flops
  assign prdata     = prdataReg;
  assign pready     = preadyReg;
  assign pslverr    = pslverrReg;
  assign prbsEnable = ctrlReg;
  assign alarmIrq   = irqReg;

endmodule

// ==== tb/channel_alarm_checker.sv ====
`timescale 1ns/10ps
module channel_alarm_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Detector levels and controls
  input wire logic [2:0]  analogLoss,
  input wire logic [2:0]  digitalLoss,
  input wire logic [2:0]  fifoLimitAlarm,
  input wire logic [2:0]  clockUnlocked,
  input wire logic [2:0]  driveMonitorFlag,
  input wire logic [2:0]  prbsEnable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // Channel 0 watched only; other channels share the same logic
  wire loss0 = analogLoss[0] | digitalLoss[0];

  // Setup cycles of reads of the alarm and change-flag words
  sequence rdA;
    psel && !penable && !pwrite && paddr == 8'h0C;
  endsequence
  sequence rdF;
    psel && !penable && !pwrite && paddr == 8'h08;
  endsequence
  sequence q;
    $stable(loss0) && $stable(driveMonitorFlag[0]);
  endsequence

  // Read word lags the live levels by the alarm register stage
  a_bit7_zero: assert property (rdA |=> !prdata[7])
    else $error("alarm bit 7 not zero");
  a_live_drive: assert property (
    rdA |=> prdata[0] == $past(driveMonitorFlag[0], 2))
    else $error("alarm bit 0 wrong");
  a_live_absent: assert property (
    rdA |=> prdata[1] == $past(loss0, 2))
    else $error("alarm bit 1 wrong");
  a_field_order: assert property (rdA |=> prdata[5:2] ==
    {$past(digitalLoss[0], 2), $past(analogLoss[0], 2),
     $past(fifoLimitAlarm[0], 2), $past(clockUnlocked[0], 2)})
    else $error("alarm bits 5..2 wrong");
  a_ready_answer: assert property (
    psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ro_refused: assert property (
    psel && !penable && pwrite && paddr == 8'h0C |=> pslverr)
    else $error("write to alarm word accepted");
  a_absent_flag: assert property (
    $changed(loss0) ##1 (!psel)[*3] ##1 rdF |=> prdata[1])
    else $error("signal-loss change flag missing");
  a_drive_flag: assert property (
    $changed(driveMonitorFlag[0]) ##1 (!psel)[*3] ##1 rdF |=> prdata[0])
    else $error("drive change flag missing");
  a_flag_clears: assert property (
    q[*2] ##0 rdF ##1 q[*2] ##1 rdF |=> prdata[1:0] == 2'h0)
    else $error("change flag survived read");
  a_lock_forced: assert property (
    (!prbsEnable[0])[*3] ##0 rdA |=> !prdata[6])
    else $error("lock lost while checker off");
endmodule

bind channel_alarm_status_bank channel_alarm_checker chk_u (
  .mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr,
  .analogLoss, .digitalLoss, .fifoLimitAlarm, .clockUnlocked,
  .driveMonitorFlag, .prbsEnable
);

// ==== tb/channel_alarm_status_bank_tb.sv ====
`timescale 1ns/10ps
module channel_alarm_status_bank_tb;
  logic        mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, alarmIrq, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0]  analogLoss = 3'h0, digitalLoss = 3'h0, fifoLimitAlarm = 3'h0;
  logic [2:0]  clockUnlocked = 3'h0, driveMonitorFlag = 3'h0, prbsEnable;
  logic [2:0]  prbsBitValid = 3'h0, prbsBitError = 3'h0;
  logic [3:0]  lostSeq = 4'h6;
  int          errs[4] = '{199, 200, 5, 4};
  int          errTotal = 0, checked = 0;

  channel_alarm_status_bank uut (
    .mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .analogLoss, .digitalLoss, .fifoLimitAlarm,
    .clockUnlocked, .driveMonitorFlag, .prbsBitValid, .prbsBitError,
    .prbsEnable, .alarmIrq
  );

  // Clock, 100 ns period
  initial forever #50 mclk = ~mclk;

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      errTotal++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, x);
    end
  endtask

  // One APB transfer; waits an edge first so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) errTotal++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog well beyond the four pattern windows
  initial begin
    repeat (8000) @(posedge mclk);
    errTotal++;
    closeOut();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    for (int c = 0; c < 3; c++) rdx(8'h0C + 8'(c * 32), 32'h0);
    apb(1'b1, 8'h2C, 32'hFF);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 8'hFC, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 8'h08, 32'h3);
    chk({31'h0, er}, 32'h1);
    rdx(8'h2C, 32'h0);
    // Unmask only the signal-loss change of channel 0
    apb(1'b1, 8'h04, 32'h2);
    rdx(8'h04, 32'h2);
    analogLoss <= 3'h1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, alarmIrq}, 32'h1);
    rdx(8'h08, 32'h2);
    rdx(8'h08, 32'h0);
    @(negedge mclk);
    chk({31'h0, alarmIrq}, 32'h0);
    // Drive change is masked, so the interrupt stays low
    @(posedge mclk);
    driveMonitorFlag <= 3'h1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, alarmIrq}, 32'h0);
    rdx(8'h08, 32'h1);
    rdx(8'h08, 32'h0);
    rdx(8'h0C, 32'h13);
    // Swapping detectors keeps the ORed state, so no change flag
    analogLoss  <= 3'h0;
    digitalLoss <= 3'h1;
    repeat (3) @(posedge mclk);
    rdx(8'h08, 32'h0);
    rdx(8'h0C, 32'h23);
    fifoLimitAlarm <= 3'h2;
    clockUnlocked  <= 3'h4;
    analogLoss     <= 3'h4;
    repeat (2) @(posedge mclk);
    rdx(8'h2C, 32'h08);
    rdx(8'h4C, 32'h16);
    // Pattern checker on; stream taken as looped back
    apb(1'b1, 8'h00, 32'h1);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 1024; i++) begin
        @(posedge mclk);
        prbsBitValid <= 3'h1;
        prbsBitError <= {2'h0, i < errs[k]};
      end
      @(posedge mclk);
      prbsBitValid <= 3'h0;
      repeat (2) @(posedge mclk);
      rdx(8'h0C, {25'h0, lostSeq[k], 6'h23});
    end
    @(negedge mclk);
    chk({29'h0, prbsEnable}, 32'h1);
    closeOut();
  end
endmodule
